// file: rtl/sarp_pkg.sv
// Shared constants and types for the serial converter readout port.
// Assumes a 50 MHz system clock; all times are converted to cycles here.
package sarp_pkg;
    localparam int RESULT_BITS   = 12;
    localparam int FRAME_BITS    = 16;
    localparam int LEAD_ZEROS    = FRAME_BITS - RESULT_BITS;
    localparam int BUFFER_DEPTH  = 2;

    localparam int CLOCK_PERIOD_NS = 20;
    localparam int CONVERT_NS      = 3300;
    localparam int DATA_HOLD_NS    = 20;

    // Least times round up; the data hold is never below one cycle
    localparam int CONVERT_CYCLES   = (CONVERT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DATA_HOLD_CYCLES = ((DATA_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS) < 1 ? 1 :
                                      ((DATA_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    localparam logic MODE_INTERNAL = 1'b0;
    localparam logic MODE_EXTERNAL = 1'b1;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_PUSH
    } sarp_conv_type;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_SHIFT,
        SER_HOLD
    } sarp_ser_type;
endpackage : sarp_pkg

// file: rtl/sarp_result_buffer.sv
// Small result FIFO between the converter and the serial shifter.
// Assumes both sides run on the same clock; pop and push may coincide.
`timescale 1ns/10ps
module sarp_result_buffer #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap by overflow, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("Buffer depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   fill;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W:0]   next_fill;
    logic             do_push;
    logic             do_pop;

    always_comb begin
        do_push     = in_valid && in_ready;
        do_pop      = out_valid && out_ready;
        next_wr_ptr = do_push ? wr_ptr + PTR_W'(1) : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + PTR_W'(1) : rd_ptr;
        next_fill   = fill;
        if (do_push && !do_pop) begin
            next_fill = fill + (PTR_W+1)'(1);
        end else if (do_pop && !do_push) begin
            next_fill = fill - (PTR_W+1)'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill   <= next_fill;
        end
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Full only counts stored words, so a stalled drain really stops the source
    assign in_ready  = (fill != (PTR_W+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = mem[rd_ptr];
endmodule : sarp_result_buffer

// file: rtl/sarp_readout_port.sv
// Digital side of a 12-bit converter with a three-wire serial readout.
// Assumes the select/convert pin and serial clock come from the host, asynchronous
// to clock; sample_code is offset-binary from the comparator on the same clock.
`timescale 1ns/10ps
module sarp_readout_port #(
    parameter int RESULT_BITS = sarp_pkg::RESULT_BITS,
    parameter int FRAME_BITS  = sarp_pkg::FRAME_BITS
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // Static configuration
    input  wire logic                   mode_select,
    // Host pins
    input  wire logic                   select_convert_pin,
    input  wire logic                   serial_clock_pin,
    output logic                        serial_result_out,
    output logic                        serial_result_oe,
    // Converter core
    input  wire logic [RESULT_BITS-1:0] sample_code,
    output logic                        track_hold,
    output logic                        conversion_busy
);
    localparam int CNT_W = 8;
    localparam int BIT_W = $clog2(FRAME_BITS + 1);

    // The frame needs at least one leading zero; counters must reach the timing counts
    if (RESULT_BITS < 2 || FRAME_BITS <= RESULT_BITS) begin : g_bad_frame
        $error("Frame must be wider than the result");
    end
    if (sarp_pkg::CONVERT_CYCLES >= (1 << CNT_W) || sarp_pkg::DATA_HOLD_CYCLES >= (1 << CNT_W)) begin : g_bad_count
        $error("Timing counts exceed counter width");
    end

    // Offset binary to two's complement is an inversion of the sign bit
    function automatic logic [RESULT_BITS-1:0] to_twos(input logic [RESULT_BITS-1:0] code);
        to_twos = {~code[RESULT_BITS-1], code[RESULT_BITS-2:0]};
    endfunction : to_twos

    // Pin synchronisers
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic sel_meta;
    logic sel_sync;
    logic sel_prev;
    logic sclk_fall;
    logic sel_fall;
    logic sel_low;
    logic mode_ext;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
            sel_meta  <= 1'b1;
            sel_sync  <= 1'b1;
            sel_prev  <= 1'b1;
        end else begin
            sclk_meta <= serial_clock_pin;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
            sel_meta  <= select_convert_pin;
            sel_sync  <= sel_meta;
            sel_prev  <= sel_sync;
        end
    end

    assign sclk_fall = sclk_prev && !sclk_sync;
    assign sel_fall  = sel_prev && !sel_sync;
    assign sel_low   = !sel_sync;
    // Mode is read live; changing it mid-frame is not supported
    assign mode_ext  = (mode_select == sarp_pkg::MODE_EXTERNAL);

    // Buffer wiring
    logic [RESULT_BITS-1:0] buf_in_data;
    logic                   buf_in_valid;
    logic                   buf_in_ready;
    logic [RESULT_BITS-1:0] buf_out_data;
    logic                   buf_out_valid;
    logic                   buf_out_ready;

    // Conversion control
    sarp_pkg::sarp_conv_type conv_state;
    sarp_pkg::sarp_conv_type next_conv_state;
    logic [CNT_W-1:0]        conv_cnt;
    logic [CNT_W-1:0]        next_conv_cnt;
    logic [RESULT_BITS-1:0]  code_reg;
    logic [RESULT_BITS-1:0]  next_code_reg;
    logic                    next_track_hold;

    always_comb begin
        next_conv_state = conv_state;
        next_conv_cnt   = conv_cnt;
        next_code_reg   = code_reg;
        unique case (conv_state)
            sarp_pkg::CONV_IDLE: begin
                next_conv_cnt = '0;
                if (sel_fall) begin
                    if (mode_ext) begin
                        next_code_reg   = to_twos(sample_code);
                        next_conv_state = sarp_pkg::CONV_PUSH;
                    end else begin
                        next_conv_state = sarp_pkg::CONV_RUN;
                    end
                end
            end
            sarp_pkg::CONV_RUN: begin
                if (mode_ext) begin
                    if (sclk_fall) begin
                        next_conv_cnt = conv_cnt + CNT_W'(1);
                    end
                    if (!sel_low || (sclk_fall && conv_cnt == CNT_W'(FRAME_BITS - 1))) begin
                        next_conv_state = sarp_pkg::CONV_IDLE;
                    end
                end else begin
                    next_conv_cnt = conv_cnt + CNT_W'(1);
                    if (conv_cnt == CNT_W'(sarp_pkg::CONVERT_CYCLES - 1)) begin
                        next_code_reg   = to_twos(sample_code);
                        next_conv_state = sarp_pkg::CONV_PUSH;
                    end
                end
            end
            sarp_pkg::CONV_PUSH: begin
                if (mode_ext && sclk_fall) begin
                    next_conv_cnt = conv_cnt + CNT_W'(1);
                end
                // A full buffer stalls here, so no result is dropped
                if (buf_in_ready) begin
                    next_conv_state = mode_ext ? sarp_pkg::CONV_RUN : sarp_pkg::CONV_IDLE;
                end
            end
        endcase
        next_track_hold = (next_conv_state == sarp_pkg::CONV_RUN) ||
                          (mode_ext && next_conv_state == sarp_pkg::CONV_PUSH);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            conv_state      <= sarp_pkg::CONV_IDLE;
            conv_cnt        <= '0;
            code_reg        <= '0;
            track_hold      <= 1'b0;
            conversion_busy <= 1'b0;
        end else begin
            conv_state      <= next_conv_state;
            conv_cnt        <= next_conv_cnt;
            code_reg        <= next_code_reg;
            track_hold      <= next_track_hold;
            conversion_busy <= next_conv_state != sarp_pkg::CONV_IDLE;
        end
    end

    assign buf_in_data  = code_reg;
    assign buf_in_valid = (conv_state == sarp_pkg::CONV_PUSH);

    sarp_result_buffer #(
        .WIDTH (RESULT_BITS),
        .DEPTH (sarp_pkg::BUFFER_DEPTH)
    ) u_buffer (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (buf_in_data),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready)
    );

    // Serial shifter
    sarp_pkg::sarp_ser_type ser_state;
    sarp_pkg::sarp_ser_type next_ser_state;
    logic [FRAME_BITS-1:0]  shift_reg;
    logic [FRAME_BITS-1:0]  next_shift_reg;
    logic [BIT_W-1:0]       bit_cnt;
    logic [BIT_W-1:0]       next_bit_cnt;
    logic [CNT_W-1:0]       hold_cnt;
    logic [CNT_W-1:0]       next_hold_cnt;
    logic                   next_out;
    logic                   next_oe;
    logic                   frame_open;

    always_comb begin
        next_ser_state = ser_state;
        next_shift_reg = shift_reg;
        next_bit_cnt   = bit_cnt;
        next_hold_cnt  = hold_cnt;
        next_out       = serial_result_out;
        next_oe        = serial_result_oe;
        buf_out_ready  = 1'b0;
        frame_open     = !mode_ext || sel_low;
        unique case (ser_state)
            sarp_pkg::SER_IDLE: begin
                next_oe  = 1'b0;
                next_out = 1'b0;
                if (buf_out_valid && frame_open) begin
                    buf_out_ready  = 1'b1;
                    next_shift_reg = {{(FRAME_BITS - RESULT_BITS){1'b0}}, buf_out_data};
                    next_out       = 1'b0;
                    next_oe        = 1'b1;
                    next_bit_cnt   = '0;
                    next_ser_state = sarp_pkg::SER_SHIFT;
                end
            end
            sarp_pkg::SER_SHIFT: begin
                if (!frame_open) begin
                    next_oe        = 1'b0;
                    next_ser_state = sarp_pkg::SER_IDLE;
                end else if (sclk_fall) begin
                    if (bit_cnt == BIT_W'(FRAME_BITS - 1)) begin
                        next_hold_cnt  = '0;
                        next_ser_state = sarp_pkg::SER_HOLD;
                    end else begin
                        next_shift_reg = {shift_reg[FRAME_BITS-2:0], 1'b0};
                        next_out       = shift_reg[FRAME_BITS-2];
                        next_bit_cnt   = bit_cnt + BIT_W'(1);
                    end
                end
            end
            sarp_pkg::SER_HOLD: begin
                next_hold_cnt = hold_cnt + CNT_W'(1);
                if (!frame_open || hold_cnt == CNT_W'(sarp_pkg::DATA_HOLD_CYCLES - 1)) begin
                    next_oe        = 1'b0;
                    next_ser_state = sarp_pkg::SER_IDLE;
                end
            end
            default: begin
                next_oe        = 1'b0;
                next_ser_state = sarp_pkg::SER_IDLE;
            end
        endcase
        // A released line rests low, so the last frame bit never lingers undriven
        if (!next_oe) begin
            next_out = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ser_state         <= sarp_pkg::SER_IDLE;
            shift_reg         <= '0;
            bit_cnt           <= '0;
            hold_cnt          <= '0;
            serial_result_out <= 1'b0;
            serial_result_oe  <= 1'b0;
        end else begin
            ser_state         <= next_ser_state;
            shift_reg         <= next_shift_reg;
            bit_cnt           <= next_bit_cnt;
            hold_cnt          <= next_hold_cnt;
            serial_result_out <= next_out;
            serial_result_oe  <= next_oe;
        end
    end
endmodule : sarp_readout_port

// file: sim/sarp_readout_port_sva.sv
// Pin-level checks for the serial converter readout port.
// Assumes host pins hold each level at least 4 clock cycles.
`timescale 1ns/10ps
module sarp_readout_port_sva #(
    parameter int RESULT_BITS = 12,
    parameter int FRAME_BITS  = 16
) (
    // Watched ports
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic                   mode_select,
    input wire logic                   select_convert_pin,
    input wire logic                   serial_clock_pin,
    input wire logic                   serial_result_out,
    input wire logic                   serial_result_oe,
    input wire logic [RESULT_BITS-1:0] sample_code,
    input wire logic                   track_hold,
    input wire logic                   conversion_busy
);
    localparam int CONV = sarp_pkg::CONVERT_CYCLES;
    logic [15:0] hold_cnt;
    logic [15:0] next_hold_cnt;
    // Counts how long the track/hold has been in hold
    always_comb next_hold_cnt = track_hold ? hold_cnt + 16'h0001 : 16'h0000;
    always_ff @(posedge clock) hold_cnt <= rst_n ? next_hold_cnt : 16'h0000;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    conv_start_a: assert property (
        !mode_select && $fell(select_convert_pin) && !conversion_busy |-> ##[1:6] (track_hold && conversion_busy))
        else $error("conversion did not start");
    hold_length_a: assert property (
        !mode_select && $fell(track_hold) |-> hold_cnt >= CONV - 1 && hold_cnt <= CONV + 1)
        else $error("hold length wrong");
    busy_hold_a: assert property (!mode_select && track_hold |-> conversion_busy)
        else $error("hold without busy");
    track_start_a: assert property (
        $rose(track_hold) |-> $past(select_convert_pin, 6) && !$past(select_convert_pin, 2))
        else $error("hold without a select fall");
    bit_step_a: assert property (
        serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out)
        |-> $past(serial_clock_pin, 5) && !$past(serial_clock_pin, 2))
        else $error("bit moved without a clock fall");
    oe_release_a: assert property (
        !mode_select && $fell(serial_result_oe) |-> $past(serial_clock_pin, 6) && !$past(serial_clock_pin, 2))
        else $error("output released without a clock fall");
    pace_end_a: assert property (
        mode_select && $fell(track_hold)
        |-> $past(select_convert_pin, 2) || (!$past(serial_clock_pin, 2) && $past(serial_clock_pin, 6)))
        else $error("hold ended without pacing");
    select_frame_a: assert property (
        (mode_select && select_convert_pin) [*6] |-> !serial_result_oe)
        else $error("driving while deselected");
    idle_out_a: assert property (!serial_result_oe |-> !serial_result_out)
        else $error("data while released");
endmodule : sarp_readout_port_sva
bind sarp_readout_port sarp_readout_port_sva #(.RESULT_BITS(RESULT_BITS), .FRAME_BITS(FRAME_BITS))
    i_sarp_readout_port_sva (.clock(clock), .rst_n(rst_n), .mode_select(mode_select),
    .select_convert_pin(select_convert_pin), .serial_clock_pin(serial_clock_pin),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .sample_code(sample_code), .track_hold(track_hold), .conversion_busy(conversion_busy));

// file: sim/sarp_host_model.sv
// Host model: drives select/convert and serial clock, reads frames.
// Assumes 50 MHz clock; pins change 1 ns after a rising edge.
`timescale 1ns/10ps
module sarp_host_model (
    // Clock and device pins
    input  wire logic clock,
    output logic      select_convert_pin,
    output logic      serial_clock_pin,
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe
);
    logic last_bit;
    logic line;
    // Released line shows the inverse of the last bit, so stale data never passes
    always @(posedge clock) if (serial_result_oe) last_bit <= serial_result_out;
    assign line = serial_result_oe ? serial_result_out : ~last_bit;
    initial begin
        select_convert_pin = 1'b1;
        serial_clock_pin   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic start_conv(input int wait_cyc);
        select_convert_pin = 1'b0;
        tick(5);
        select_convert_pin = 1'b1;
        tick(wait_cyc);
    endtask : start_conv
    // Each bit is read while the serial clock is high, just before the falling edge that advances it
    task automatic read_frame(input int n, output logic [15:0] word);
        word = 16'h0000;
        for (int k = 0; k < n; k++) begin
            serial_clock_pin = 1'b1;
            tick(4);
            word = {word[14:0], line};
            serial_clock_pin = 1'b0;
            tick(4);
        end
        tick(6);
    endtask : read_frame
    task automatic ext_frame(input int n, output logic [15:0] word);
        select_convert_pin = 1'b0;
        tick(10);
        read_frame(n, word);
        select_convert_pin = 1'b1;
        tick(6);
    endtask : ext_frame
endmodule : sarp_host_model

// file: sim/sarp_readout_port_tb.sv
// Self-checking bench for the serial converter readout port.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
module sarp_readout_port_tb;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        mode_select = 1'b0;
    logic [11:0] sample_code = 12'h000;
    logic        select_convert_pin;
    logic        serial_clock_pin;
    logic        serial_result_out;
    logic        serial_result_oe;
    logic        track_hold;
    logic        conversion_busy;
    logic [15:0] word;
    int          errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    sarp_readout_port i_sarp_readout_port (.clock(clock), .rst_n(rst_n), .mode_select(mode_select),
        .select_convert_pin(select_convert_pin), .serial_clock_pin(serial_clock_pin),
        .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
        .sample_code(sample_code), .track_hold(track_hold), .conversion_busy(conversion_busy));
    sarp_host_model i_sarp_host_model (.clock(clock), .select_convert_pin(select_convert_pin),
        .serial_clock_pin(serial_clock_pin), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe));
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            $display("BAD %0t timeout", $time);
            errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit
    // Offset code to two's complement frame: four zeros, then sign-flipped code
    function automatic logic [15:0] frame_of(input logic [11:0] code);
        return {4'h0, ~code[11], code[10:0]};
    endfunction : frame_of
    // Mode only changes under reset
    task automatic do_reset(input logic mode);
        rst_n = 1'b0;
        mode_select = mode;
        i_sarp_host_model.tick(2);
        rst_n = 1'b1;
        i_sarp_host_model.tick(2);
    endtask : do_reset
    task automatic internal_frames();
        logic [11:0] codes [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h5A3};
        foreach (codes[i]) begin
            sample_code = codes[i];
            i_sarp_host_model.start_conv(180);
            check_bit(conversion_busy, 1'b0);
            check_bit(serial_result_oe, 1'b1);
            i_sarp_host_model.read_frame(16, word);
            check_word(word, frame_of(codes[i]));
            check_bit(serial_result_oe, 1'b0);
        end
    endtask : internal_frames
    // Results queue unread; the fourth stalls until the reader drains one
    task automatic buffer_stall();
        logic [11:0] codes [4] = '{12'h123, 12'h9AB, 12'hC01, 12'h3FE};
        foreach (codes[i]) begin
            sample_code = codes[i];
            i_sarp_host_model.start_conv(180);
        end
        check_bit(conversion_busy, 1'b1);
        check_bit(track_hold, 1'b0);
        foreach (codes[i]) begin
            i_sarp_host_model.read_frame(16, word);
            check_word(word, frame_of(codes[i]));
        end
        check_bit(conversion_busy, 1'b0);
    endtask : buffer_stall
    task automatic external_frames();
        logic [11:0] codes [2] = '{12'h801, 12'h7FE};
        foreach (codes[i]) begin
            sample_code = codes[i];
            i_sarp_host_model.ext_frame(16, word);
            check_word(word, frame_of(codes[i]));
            check_bit(track_hold, 1'b0);
        end
    endtask : external_frames
    task automatic external_abort();
        logic [15:0] exp;
        sample_code = 12'h456;
        exp = frame_of(12'h456);
        i_sarp_host_model.ext_frame(6, word);
        check_word({10'h000, word[5:0]}, {10'h000, exp[15:10]});
        check_bit(serial_result_oe, 1'b0);
    endtask : external_abort
    initial begin
        do_reset(1'b0);
        internal_frames();
        buffer_stall();
        do_reset(1'b1);
        external_frames();
        external_abort();
        final_report();
    end
endmodule : sarp_readout_port_tb
